// File: hw/lan_defines.svh
`ifndef LAN_DEFINES_SVH
`define LAN_DEFINES_SVH

// Management register numbers.
`define LAN_REG_W 16
`define LAN_REG_CTRL 5'h00
`define LAN_REG_STAT 5'h01
`define LAN_REG_ADV 5'h04
`define LAN_REG_LPA 5'h05
`define LAN_REG_EXP 5'h06
`define LAN_REG_QSTAT 5'h11

// Basic control fields and values.
`define LAN_CTRL_RESET 15
`define LAN_CTRL_SPEED 13
`define LAN_CTRL_ANEN 12
`define LAN_CTRL_RESTART 9
`define LAN_CTRL_DUPLEX 8
`define LAN_CTRL_RST_VAL 16'h3100
`define LAN_CTRL_WR_MASK 16'h3100

// Basic status fields; the fixed part reports the four abilities.
`define LAN_STAT_FIXED 16'h7809
`define LAN_STAT_ANDONE 5
`define LAN_STAT_LINK 2

// Ability bit positions shared by the advertisement and partner words.
`define LAN_ADV_RST_VAL 16'h01E1
`define LAN_AB_100FD 8
`define LAN_AB_T4 9
`define LAN_AB_100HD 7
`define LAN_AB_10FD 6
`define LAN_AB_10HD 5

// Expansion and consolidated status fields.
`define LAN_EXP_LPCAP 0
`define LAN_EXP_PDF 4
`define LAN_QS_RATE 15
`define LAN_QS_DPX 14
`define LAN_QS_ANDONE 4
`define LAN_QS_NOSIG 3
`define LAN_QS_LINK 0

// Serial management frame.
`define LAN_MD_ONES_W 6
`define LAN_MD_PRE_ONES 6'h20
`define LAN_MD_OP_RD 2'h2
`define LAN_MD_OP_WR 2'h1
`define LAN_MD_HDR_LAST 5'h0C
`define LAN_MD_DATA_LAST 5'h0F
`define LAN_MD_PHY_ADDR 5'h01

// Burst timing.
`define LAN_GAP_W 24
`define LAN_CLK_MHZ 50
`define LAN_BURST_GAP_US 16000
`define LAN_PD_BURSTS 7

`endif

// File: hw/lan_pkg.sv
`include "lan_defines.svh"

package lan_pkg;

    typedef enum logic [2:0] {
        LAN_TECH_NONE, LAN_TECH_10HD, LAN_TECH_10FD, LAN_TECH_100HD, LAN_TECH_100FD
    } lan_tech_type;

    typedef enum logic [1:0] {LAN_AN_OFF, LAN_AN_TX, LAN_AN_DONE, LAN_AN_FAULT} lan_an_type;

    typedef enum logic [2:0] {LAN_MD_PRE, LAN_MD_HDR, LAN_MD_TA, LAN_MD_RD, LAN_MD_WR} lan_md_type;

    typedef struct packed {
        logic flp_valid;
        logic [`LAN_REG_W-1:0] flp_word;
        logic nlp_seen;
        logic idle100_seen;
        logic link_ok;
    } lan_line_rx_type;

    typedef struct packed {
        logic burst;
        logic [`LAN_REG_W-1:0] code_word;
    } lan_line_tx_type;

    typedef struct packed {
        logic en_100tx;
        logic en_10t;
        logic full_duplex;
    } lan_path_type;

    typedef struct packed {
        lan_md_type md;
        logic [`LAN_MD_ONES_W-1:0] ones;
        logic [4:0] cnt;
        logic [`LAN_REG_W-1:0] sh;
        logic rd_op;
        logic [4:0] reg_addr;
        logic mdc_prev;
        logic mdio_out;
        logic mdio_oe;
        logic [`LAN_REG_W-1:0] ctrl;
        logic [`LAN_REG_W-1:0] adv;
        logic [`LAN_REG_W-1:0] lpa;
        logic lp_cap;
        logic pd_fault;
        logic an_done;
        lan_an_type an;
        lan_tech_type tech;
        logic [`LAN_GAP_W-1:0] gap;
        logic [3:0] bursts;
        logic saw_nlp;
        logic saw_idle;
        logic link_prev;
        lan_line_tx_type tx;
        lan_path_type path;
    } lan_state_type;

endpackage

// File: hw/lan_sync.sv
`timescale 1ns/100ps
`default_nettype none

module lan_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [1:0][W-1:0] pipe_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pipe_q <= '0;
        end else begin
            pipe_q <= {pipe_q[0], d};
        end
    end

    assign q = pipe_q[1];

endmodule

`default_nettype wire

// File: hw/lan_autoneg.sv
// Overview of operation
// R1: Negotiation runs only while it is enabled here and the partner answers with its own bursts.
// R2: Each outgoing burst carries the word held in the local advertisement register 4.
// R3: While negotiating, fast pulse bursts replace normal pulses, each with a link code word.
// R4: The ability word decoded from the partner's bursts is stored in partner register 5.
// R5: The chosen technology is the highest common one of 100TX-FD, T4, 100TX-HD, 10T-FD, 10T-HD; a common T4 without 100TX-FD selects none here.
// R6: On completion the completion flag is set in basic status and in the consolidated status.
// R7: After success the transmit and receive paths of the chosen technology are enabled.
// R8: After success every technology that was not chosen is switched off.
// R9: A non-negotiating 10Base-T partner is detected by its pulses and 10Base-T is chosen.
// R10: Registers are reached over the two-wire management clock and data interface.
// R11: A consolidated status register returns link and negotiation state in one read.
// R12: Negotiation restarts on link failure, on the restart bit, or on an enable off-on cycle; here link failure restarts it only after completion.
// R13: With no answering bursts, parallel detection clears the capable flag and sets one ability.
// R14: More than one detected technology enables none and sets the parallel detection fault.
// R15: Every management register is a 16-bit word with flags addressed by register and bit.
`timescale 1ns/100ps
`default_nettype none

`include "lan_defines.svh"

module lan_autoneg
    import lan_pkg::*;
#(
    parameter int BURST_GAP_CYC = `LAN_BURST_GAP_US * `LAN_CLK_MHZ,
    parameter logic [3:0] PD_BURSTS = 4'(`LAN_PD_BURSTS),
    parameter logic [4:0] PHY_ADDR = `LAN_MD_PHY_ADDR
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    input wire logic negotiation_select_pin,
    input wire logic hw_mode_pin,
    input wire lan_line_rx_type line_rx,
    output lan_line_tx_type line_tx,
    output lan_path_type path
);

    localparam logic [`LAN_GAP_W-1:0] GAP_RELOAD = `LAN_GAP_W'(BURST_GAP_CYC - 1);

    logic [1:0] rst_pipe_q;
    logic rst_n;
    logic mdc_s;
    logic mdio_s;
    logic sel_s;
    logic hw_s;
    lan_state_type s;
    lan_state_type n;
    logic mdc_rise;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [`LAN_REG_W-1:0] wr_data;
    logic [12:0] hdr;
    logic soft_rst;
    logic restart;
    logic an_en;
    logic link_fail;
    lan_tech_type forced;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe_q[1];

    lan_sync #(
        .W(4)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({mdc, mdio_in, negotiation_select_pin, hw_mode_pin}),
        .q({mdc_s, mdio_s, sel_s, hw_s})
    );

    // Highest common ability; a common T4 bit without 100TX-FD selects no technology.
    function automatic lan_tech_type resolve(input logic [`LAN_REG_W-1:0] common);
        lan_tech_type t;
        t = LAN_TECH_NONE;
        if (common[`LAN_AB_100FD]) begin
            t = LAN_TECH_100FD;
        end else if (common[`LAN_AB_T4]) begin
            t = LAN_TECH_NONE;
        end else if (common[`LAN_AB_100HD]) begin
            t = LAN_TECH_100HD;
        end else if (common[`LAN_AB_10FD]) begin
            t = LAN_TECH_10FD;
        end else if (common[`LAN_AB_10HD]) begin
            t = LAN_TECH_10HD;
        end
        return t; // [R5]
    endfunction

    function automatic logic [`LAN_REG_W-1:0] rd_word(input lan_state_type st,
                                                       input logic [4:0] addr,
                                                       input logic link_ok);
        logic [`LAN_REG_W-1:0] w;
        logic up;
        w = '0;
        up = link_ok && (st.tech != LAN_TECH_NONE);
        unique case (addr)
            `LAN_REG_CTRL: w = st.ctrl;
            `LAN_REG_STAT: begin
                w = `LAN_STAT_FIXED;
                w[`LAN_STAT_ANDONE] = st.an_done; // [R6]
                w[`LAN_STAT_LINK] = up;
            end
            `LAN_REG_ADV: w = st.adv;
            `LAN_REG_LPA: w = st.lpa;
            `LAN_REG_EXP: begin
                w[`LAN_EXP_LPCAP] = st.lp_cap;
                w[`LAN_EXP_PDF] = st.pd_fault;
            end
            `LAN_REG_QSTAT: begin
                w[`LAN_QS_RATE] = st.path.en_100tx; // [R11]
                w[`LAN_QS_DPX] = st.path.full_duplex;
                w[`LAN_QS_ANDONE] = st.an_done; // [R6]
                w[`LAN_QS_NOSIG] = !link_ok;
                w[`LAN_QS_LINK] = up;
            end
            default: w = '0;
        endcase
        return w; // [R15]
    endfunction

    assign hdr = {s.sh[11:0], mdio_s};
    assign an_en = hw_s ? sel_s : s.ctrl[`LAN_CTRL_ANEN];
    assign link_fail = s.link_prev && !line_rx.link_ok;
    assign forced = s.ctrl[`LAN_CTRL_SPEED]
        ? (s.ctrl[`LAN_CTRL_DUPLEX] ? LAN_TECH_100FD : LAN_TECH_100HD)
        : (s.ctrl[`LAN_CTRL_DUPLEX] ? LAN_TECH_10FD : LAN_TECH_10HD);

    always_comb begin
        n = s;
        wr_en = 1'b0;
        wr_addr = '0;
        wr_data = '0;
        soft_rst = 1'b0;
        restart = 1'b0;
        n.tx.burst = 1'b0;
        n.mdc_prev = mdc_s;
        n.link_prev = line_rx.link_ok;
        mdc_rise = mdc_s && !s.mdc_prev;

        // Management frame: preamble, start, opcode, addresses, turnaround, data.
        if (mdc_rise) begin
            unique case (s.md)
                LAN_MD_PRE: begin
                    if (mdio_s) begin
                        if (s.ones != `LAN_MD_PRE_ONES) begin
                            n.ones = s.ones + 1'b1;
                        end
                    end else begin
                        n.ones = '0;
                        if (s.ones == `LAN_MD_PRE_ONES) begin
                            n.md = LAN_MD_HDR; // [R10]
                            n.cnt = '0;
                        end
                    end
                end
                LAN_MD_HDR: begin
                    n.sh = {s.sh[14:0], mdio_s};
                    n.cnt = s.cnt + 1'b1;
                    if (s.cnt == `LAN_MD_HDR_LAST) begin
                        n.cnt = '0;
                        n.reg_addr = hdr[4:0];
                        n.md = LAN_MD_PRE;
                        if (hdr[12] && hdr[9:5] == PHY_ADDR) begin
                            if (hdr[11:10] == `LAN_MD_OP_RD) begin
                                n.md = LAN_MD_TA;
                                n.rd_op = 1'b1;
                                n.sh = rd_word(s, hdr[4:0], line_rx.link_ok);
                            end else if (hdr[11:10] == `LAN_MD_OP_WR) begin
                                n.md = LAN_MD_TA;
                                n.rd_op = 1'b0;
                            end
                        end
                    end
                end
                LAN_MD_TA: begin
                    if (s.cnt == '0) begin
                        n.cnt = 5'h01;
                        n.mdio_oe = s.rd_op;
                        n.mdio_out = 1'b0;
                    end else begin
                        n.cnt = '0;
                        if (s.rd_op) begin
                            n.md = LAN_MD_RD;
                            n.mdio_out = s.sh[15];
                            n.sh = {s.sh[14:0], 1'b0};
                        end else begin
                            n.md = LAN_MD_WR;
                        end
                    end
                end
                LAN_MD_RD: begin
                    if (s.cnt == `LAN_MD_DATA_LAST) begin
                        n.md = LAN_MD_PRE;
                        n.mdio_oe = 1'b0;
                        n.mdio_out = 1'b0;
                    end else begin
                        n.cnt = s.cnt + 1'b1;
                        n.mdio_out = s.sh[15];
                        n.sh = {s.sh[14:0], 1'b0};
                    end
                end
                LAN_MD_WR: begin
                    n.sh = {s.sh[14:0], mdio_s};
                    n.cnt = s.cnt + 1'b1;
                    if (s.cnt == `LAN_MD_DATA_LAST) begin
                        n.md = LAN_MD_PRE;
                        wr_en = 1'b1;
                        wr_addr = s.reg_addr;
                        wr_data = {s.sh[14:0], mdio_s};
                    end
                end
            endcase
        end

        // Reset and restart bits clear themselves; only stored fields read back.
        if (wr_en) begin
            if (wr_addr == `LAN_REG_CTRL) begin
                soft_rst = wr_data[`LAN_CTRL_RESET];
                restart = wr_data[`LAN_CTRL_RESTART];
                n.ctrl = wr_data & `LAN_CTRL_WR_MASK;
            end else if (wr_addr == `LAN_REG_ADV) begin
                n.adv = wr_data; // [R2]
            end
        end

        if (!an_en) begin
            n.an = LAN_AN_OFF;
            n.an_done = 1'b0;
            n.tech = forced;
        end else if (restart || s.an == LAN_AN_OFF ||
                     (link_fail && s.an == LAN_AN_DONE)) begin
            n.an = LAN_AN_TX; // [R12]
            n.gap = '0;
            n.bursts = '0;
            n.saw_nlp = 1'b0;
            n.saw_idle = 1'b0;
            n.an_done = 1'b0;
            n.tech = LAN_TECH_NONE;
        end else begin
            unique case (s.an)
                LAN_AN_TX: begin
                    if (s.gap == '0) begin
                        n.tx.burst = 1'b1; // [R3]
                        n.tx.code_word = s.adv; // [R2]
                        n.gap = GAP_RELOAD;
                        if (s.bursts != PD_BURSTS) begin
                            n.bursts = s.bursts + 1'b1;
                        end
                    end else begin
                        n.gap = s.gap - 1'b1;
                    end
                    n.saw_nlp = s.saw_nlp || line_rx.nlp_seen;
                    n.saw_idle = s.saw_idle || line_rx.idle100_seen;
                    if (line_rx.flp_valid) begin
                        n.lpa = line_rx.flp_word; // [R4]
                        n.lp_cap = 1'b1; // [R1]
                        n.tech = resolve(s.adv & line_rx.flp_word); // [R5]
                        n.an_done = 1'b1; // [R6]
                        n.an = LAN_AN_DONE;
                    end else if (s.bursts == PD_BURSTS) begin
                        if (s.saw_nlp && s.saw_idle) begin
                            n.pd_fault = 1'b1; // [R14]
                            n.tech = LAN_TECH_NONE; // [R14]
                            n.an = LAN_AN_FAULT;
                        end else if (s.saw_nlp || s.saw_idle) begin
                            n.lp_cap = 1'b0; // [R13]
                            n.lpa = s.saw_nlp ? (16'h0001 << `LAN_AB_10HD)
                                              : (16'h0001 << `LAN_AB_100HD); // [R13]
                            n.tech = s.saw_nlp ? LAN_TECH_10HD : LAN_TECH_100HD; // [R9]
                            n.an_done = 1'b1; // [R13]
                            n.an = LAN_AN_DONE;
                        end else begin
                            n.bursts = '0;
                            n.saw_nlp = 1'b0;
                            n.saw_idle = 1'b0;
                        end
                    end
                end
                LAN_AN_DONE: n.an = LAN_AN_DONE;
                LAN_AN_FAULT: n.an = LAN_AN_FAULT;
                LAN_AN_OFF: n.an = LAN_AN_TX;
            endcase
        end

        if (soft_rst) begin
            n.ctrl = `LAN_CTRL_RST_VAL;
            n.adv = `LAN_ADV_RST_VAL;
            n.lpa = '0;
            n.lp_cap = 1'b0;
            n.pd_fault = 1'b0;
            n.an_done = 1'b0;
            n.an = LAN_AN_OFF;
            n.tech = LAN_TECH_NONE;
        end

        // Only the chosen datapath is powered; all others stay off.
        n.path.en_100tx = (n.tech == LAN_TECH_100HD) || (n.tech == LAN_TECH_100FD); // [R7] [R8]
        n.path.en_10t = (n.tech == LAN_TECH_10HD) || (n.tech == LAN_TECH_10FD); // [R7] [R8]
        n.path.full_duplex = (n.tech == LAN_TECH_100FD) || (n.tech == LAN_TECH_10FD);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ctrl <= `LAN_CTRL_RST_VAL;
            s.adv <= `LAN_ADV_RST_VAL;
        end else begin
            s <= n;
        end
    end

    assign mdio_out = s.mdio_out;
    assign mdio_oe = s.mdio_oe;
    assign line_tx = s.tx;
    assign path = s.path;

endmodule

`default_nettype wire

// File: dv/lan_autoneg_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module lan_autoneg_monitor
    import lan_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire lan_line_rx_type line_rx,
    input wire lan_line_tx_type line_tx,
    input wire lan_path_type path
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    chk_word_holds: assert property (!line_tx.burst |-> $stable(line_tx.code_word))
        else $error("code word changed outside a burst");
    chk_burst_single: assert property (line_tx.burst |=> !line_tx.burst)
        else $error("burst start wider than one cycle");
    chk_burst_quiet: assert property ((path.en_100tx || path.en_10t) |-> !line_tx.burst)
        else $error("burst sent while a datapath is enabled");
    chk_one_tech: assert property (!(path.en_100tx && path.en_10t))
        else $error("two technologies enabled together");
    chk_link_restart: assert property (
        $fell(line_rx.link_ok) && (path.en_100tx || path.en_10t)
        |=> !path.en_100tx && !path.en_10t)
        else $error("datapath kept after link failure");
    chk_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
        else $error("turnaround bit not driven low");
    chk_ta_len: assert property ($rose(mdio_oe) |-> mdio_oe [*5])
        else $error("data line released too early");
    chk_oe_after_mdc: assert property ($rose(mdio_oe) |-> $past(mdc, 2))
        else $error("data line driven without a clock edge");

    cover property (line_tx.burst);
    cover property ($rose(path.en_10t));
    cover property ($rose(path.en_100tx && path.full_duplex));
    cover property ($rose(mdio_oe));
endmodule

`default_nettype wire

// File: dv/lan_partner.sv
`timescale 1ns/100ps
`default_nettype none

module lan_partner
    import lan_pkg::*;
(
    input wire logic clk_sys,
    input wire lan_line_tx_type line_tx,
    input wire logic flp_on,
    input wire logic [15:0] word,
    input wire logic nlp_on,
    input wire logic idle_on,
    input wire logic link_up,
    output lan_line_rx_type line_rx
);
    logic [2:0] dly_q = 3'h0;

    // A negotiating partner answers each burst a few cycles later.
    always_ff @(posedge clk_sys) begin
        dly_q <= {dly_q[1:0], line_tx.burst & flp_on};
    end

    // Outside a valid pulse the word shows garbage, never the last value.
    always_comb begin
        line_rx.flp_valid = dly_q[2];
        line_rx.flp_word = dly_q[2] ? word : ~word;
        line_rx.nlp_seen = nlp_on;
        line_rx.idle100_seen = idle_on;
        line_rx.link_ok = link_up;
    end
endmodule

`default_nettype wire

// File: dv/lan_autoneg_test.sv
`timescale 1ns/100ps
`default_nettype none

module lan_autoneg_test
    import lan_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic mdc = 1'b0;
    logic tb_oe = 1'b0;
    logic tb_bit = 1'b1;
    logic sel_pin = 1'b1;
    logic hw_mode = 1'b0;
    logic flp_on = 1'b1;
    logic nlp_on = 1'b0;
    logic idle_on = 1'b0;
    logic link_up = 1'b1;
    logic [15:0] word = 16'h01E1;
    logic mdio_out;
    logic mdio_oe;
    logic mdio_in;
    lan_line_rx_type line_rx;
    lan_line_tx_type line_tx;
    lan_path_type path;
    int failures = 0;
    int n_compared = 0;
    logic [15:0] adv_t [6] = '{16'h01E1, 16'h01E1, 16'h01E1, 16'h01E1, 16'h01E1, 16'h0061};
    logic [15:0] lp_t [6] = '{16'h01E1, 16'h00A1, 16'h0061, 16'h0021, 16'h0201, 16'h01E1};
    logic [15:0] qs_t [6] = '{16'hC011, 16'h8011, 16'h4011, 16'h0011, 16'h0010, 16'h4011};
    logic [2:0] p_t [6] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h0, 3'h3};
    logic [15:0] pd_lp [3] = '{16'h0020, 16'h0080, 16'h0080};
    logic [15:0] pd_x [3] = '{16'h0000, 16'h0000, 16'h0010};
    logic [2:0] pd_p [3] = '{3'h2, 3'h4, 3'h0};
    logic [15:0] pd_q [3] = '{16'h0011, 16'h8011, 16'h0000};

    // The management line has a pull-up when nobody drives it.
    assign mdio_in = mdio_oe ? mdio_out : (tb_oe ? tb_bit : 1'b1);

    always #10 clk_sys = ~clk_sys;

    lan_autoneg #(.BURST_GAP_CYC(20), .PD_BURSTS(4'h2), .PHY_ADDR(5'h01)) dut_u (
        .clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .negotiation_select_pin(sel_pin),
        .hw_mode_pin(hw_mode), .line_rx(line_rx), .line_tx(line_tx), .path(path)
    );

    lan_partner partner_u (
        .clk_sys(clk_sys), .line_tx(line_tx), .flp_on(flp_on), .word(word),
        .nlp_on(nlp_on), .idle_on(idle_on), .link_up(link_up), .line_rx(line_rx)
    );

    task automatic summarize();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One 64-bit frame, eight system clocks per management clock.
    task automatic md_frame(input logic wr, input logic [4:0] ra, input logic [15:0] wd,
            output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, 2'h1, wr ? 2'h1 : 2'h2, 5'h01, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--) begin
            tb_oe = wr || i > 17;
            tb_bit = f[i];
            mdc = 1'b0;
            repeat (4) @(negedge clk_sys);
            rd = {rd[14:0], mdio_in};
            mdc = 1'b1;
            repeat (4) @(negedge clk_sys);
        end
        tb_oe = 1'b0;
        // Let one clock pass so that the next frame never drives the line in this time step.
        @(negedge clk_sys);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] r;
        md_frame(1'b1, ra, d, r);
    endtask

    task automatic rchk(input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] r;
        md_frame(1'b0, ra, 16'h0000, r);
        chk(r, e);
    endtask

    task automatic t_reset();
        int n;
        n = 0;
        chk({13'h0, path}, 16'h0000);
        while (line_tx.burst !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        chk({15'h0, line_tx.burst}, 16'h0001);
        chk(line_tx.code_word, 16'h01E1);
        rchk(5'h00, 16'h3100);
        rchk(5'h04, 16'h01E1);
        rchk(5'h02, 16'h0000);
        rchk(5'h01, 16'h782D);
        rchk(5'h06, 16'h0001);
        chk({13'h0, path}, 16'h0005);
    endtask

    task automatic t_prio();
        for (int i = 0; i < 6; i++) begin
            word = lp_t[i];
            wr(5'h04, adv_t[i]);
            wr(5'h00, 16'h3300);
            rchk(5'h05, lp_t[i]);
            rchk(5'h11, qs_t[i]);
            chk({13'h0, path}, {13'h0, p_t[i]});
            chk(line_tx.code_word, adv_t[i]);
        end
        wr(5'h04, 16'h01E1);
    endtask

    task automatic t_pd();
        flp_on = 1'b0;
        for (int i = 0; i < 3; i++) begin
            nlp_on = (i != 1);
            idle_on = (i != 0);
            wr(5'h00, 16'h3300);
            rchk(5'h05, pd_lp[i]);
            rchk(5'h06, pd_x[i]);
            rchk(5'h11, pd_q[i]);
            chk({13'h0, path}, {13'h0, pd_p[i]});
        end
        nlp_on = 1'b0;
        idle_on = 1'b0;
        flp_on = 1'b1;
    endtask

    task automatic t_link();
        word = 16'h01E1;
        wr(5'h00, 16'h3300);
        rchk(5'h01, 16'h782D);
        link_up = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk({13'h0, path}, 16'h0000);
        link_up = 1'b1;
        rchk(5'h11, 16'hC011);
    endtask

    task automatic t_enable();
        wr(5'h00, 16'h0000);
        rchk(5'h00, 16'h0000);
        chk({13'h0, path}, 16'h0002);
        wr(5'h00, 16'h3100);
        rchk(5'h00, 16'h3100);
        chk({13'h0, path}, 16'h0005);
    endtask

    task automatic t_hwpin();
        word = 16'h0021;
        hw_mode = 1'b1;
        sel_pin = 1'b0;
        repeat (10) @(negedge clk_sys);
        sel_pin = 1'b1;
        rchk(5'h05, 16'h0021);
        chk({13'h0, path}, 16'h0002);
        hw_mode = 1'b0;
    endtask

    // The fault flag survives restarts; a soft reset clears it and restores the registers.
    task automatic t_soft();
        rchk(5'h06, 16'h0011);
        wr(5'h04, 16'h0021);
        wr(5'h00, 16'h8000);
        rchk(5'h00, 16'h3100);
        rchk(5'h04, 16'h01E1);
        rchk(5'h06, 16'h0001);
        chk({13'h0, path}, 16'h0002);
    endtask

    initial begin
        repeat (3) @(negedge clk_sys);
        nrst = 1'b1;
        t_reset();
        t_prio();
        t_pd();
        t_link();
        t_enable();
        t_hwpin();
        t_soft();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        summarize();
    end
endmodule

bind lan_autoneg lan_autoneg_monitor mon_u (
    .clk_sys(clk_sys), .nrst(nrst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .line_rx(line_rx), .line_tx(line_tx), .path(path)
);

`default_nettype wire
